// ---- hw/fas_sequencer.sv ----
// Functional notes
// - Four-bit length code latched from its inputs when length select and strobe are high.
// - Length codes 0 to 15 give transforms of 2 to 65536 points.
// - Butterfly counter is a stage counter plus a row counter within the stage.
// - Two select inputs pick Reset, Reset/Load, Count or Hold, acting at the clock edge.
// - Count steps to the next butterfly; Hold keeps the present position.
// - Stage-done flag is high while at the last butterfly of the stage.
// - Transform-done flag is high while at the final butterfly of the transform.
// - Stage parity toggles at each completed stage, for memory swapping.
// - Parity and nonzero-coefficient share one output; nonzero shows for real-input data addresses.
// - Data and coefficient addresses are derived from the counter state by logic.
// - Digit-reversal side, decimation type and radix configure the address generators.
// - Data and coefficient addresses are sixteen bits wide.
// - Radix 2 or 4, time or frequency decimation, digit reversal on input or output, complex or real input.
// - Radix-2: log2 N stages of N/2 butterflies; stage m has 2^(m-1) groups.
// - Coefficient changes per group: zero then bit-reversed group index scaled by pi/N.
// - Sixteen points: stage one 0,8,1,9..7,15; stage two 0,4,1,5.. then 8,12..
// - Configuration bits latched when configuration select and strobe are high.
// - Source select picks the driven address; output enable low floats the address lines.
// - Reset clears unused upper bits; Reset/Load takes them from the address lines.
// - Coefficient address A means angle 2*pi*A/65536; only needed angles are issued.
`timescale 1ns/1ps
`include "fas_defines.svh"

module fas_sequencer (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic instr_select_low, // Instruction select bit 0
  input wire logic instr_select_high, // Instruction select bit 1
  input wire logic [3:0] length_code_inputs, // Transform length code
  input wire logic length_latch_select, // Length latch select
  input wire logic length_latch_strobe, // Length latch strobe
  input wire logic digit_reversal_side_select, // 1: reversed data addresses on input side
  input wire logic decimation_type_select, // 1: decimation in time
  input wire logic radix_select, // 1: radix 4
  input wire logic config_latch_select, // Configuration latch select
  input wire logic config_latch_strobe, // Configuration latch strobe
  input wire logic [3:0] address_source_select, // [3:2] source, [1:0] butterfly leg
  input wire logic output_enable, // High drives the address lines
  input wire logic [15:0] addr_in, // Address lines as seen from outside
  output logic [15:0] addr_out, // Address lines driven value
  output logic addr_oe, // Address line output enable
  output logic stage_done_flag, // Last butterfly of the stage
  output logic transform_done_flag, // Final butterfly of the transform
  output logic parity_nonzero_flag, // Stage parity or nonzero coefficient
  input wire logic [7:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI write address valid
  output logic s_axi_awready, // AXI write address ready
  input wire logic [31:0] s_axi_wdata, // AXI write data
  input wire logic [3:0] s_axi_wstrb, // AXI write strobes
  input wire logic s_axi_wvalid, // AXI write data valid
  output logic s_axi_wready, // AXI write data ready
  output logic [1:0] s_axi_bresp, // AXI write response
  output logic s_axi_bvalid, // AXI write response valid
  input wire logic s_axi_bready, // AXI write response ready
  input wire logic [7:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI read address valid
  output logic s_axi_arready, // AXI read address ready
  output logic [31:0] s_axi_rdata, // AXI read data
  output logic [1:0] s_axi_rresp, // AXI read response
  output logic s_axi_rvalid, // AXI read data valid
  input wire logic s_axi_rready // AXI read data ready
);

  logic [4:0] stage_ff, nxt_stage;
  logic [15:0] row_ff, nxt_row;
  logic [15:0] base_ff, nxt_base;
  logic parity_ff, nxt_parity;
  logic [3:0] len_ff, nxt_len;
  logic [2:0] cfg_ff, nxt_cfg;
  logic [15:0] addr_ff, nxt_addr;
  logic oe_ff, sdone_ff, nxt_sdone, tdone_ff, nxt_tdone, flag_ff, nxt_flag;
  logic rvi_mode;
  fas_pkg::fas_instr_type instr;
  logic [4:0] pts_bits, n_pts_bits, n_stages;
  logic [1:0] n_w;
  logic [15:0] cur_rows_last, n_rows_last;
  logic [4:0] cur_stages;
  logic cur_sdone, cur_tdone;
  logic [4:0] s_eff;
  logic [1:0] leg;
  logic [15:0] gen_a, din_a, dout_a, coef_a;

  // Digit width: radix 4 steps two address bits per stage, if the length is a power of four
  function automatic logic [1:0] fas_width(input logic [3:0] len, input logic r4);
    return (r4 && len[0]) ? 2'h2 : 2'h1;
  endfunction

  // Last row index of a stage: N/2 or N/4 butterflies
  function automatic logic [15:0] fas_rows_last(input logic [4:0] bits, input logic [1:0] w);
    logic [16:0] v;
    v = (17'h00001 << (bits - 5'(w))) - 17'h00001;
    return v[15:0];
  endfunction

  function automatic logic [15:0] fas_bitrev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15-i];
    end
    return r;
  endfunction

  function automatic logic [15:0] fas_low_mask(input logic [4:0] bits);
    logic [16:0] m;
    m = (17'h00001 << bits) - 17'h00001;
    return m[15:0];
  endfunction

  // Bit position of the active digit in stage se
  function automatic logic [4:0] fas_digit_pos(input logic [4:0] bits, input logic [1:0] w, input logic [4:0] se);
    int b;
    b = int'(bits) - int'(w) * (int'(se) + 1);
    if (b < 0) begin
      b = 0;
    end
    return 5'(b);
  endfunction

  assign instr = {instr_select_high, instr_select_low};

  // Present-state limits, used by the counter
  always_comb begin
    pts_bits = 5'(len_ff) + 5'h01;
    cur_stages = (fas_width(len_ff, cfg_ff[0]) == 2'h2) ? (pts_bits >> 1) : pts_bits;
    cur_rows_last = fas_rows_last(pts_bits, fas_width(len_ff, cfg_ff[0]));
    cur_sdone = (row_ff == cur_rows_last);
    cur_tdone = cur_sdone && (stage_ff == cur_stages - 5'h01);
  end

  // Latches and butterfly counter
  always_comb begin
    nxt_len = len_ff;
    nxt_cfg = cfg_ff;
    nxt_stage = stage_ff;
    nxt_row = row_ff;
    nxt_base = base_ff;
    nxt_parity = parity_ff;
    if (length_latch_select && length_latch_strobe) begin
      nxt_len = length_code_inputs;
    end
    if (config_latch_select && config_latch_strobe) begin
      nxt_cfg = {digit_reversal_side_select, decimation_type_select, radix_select};
    end
    case (instr)
      `FAS_INSTR_RESET: begin
        nxt_stage = 5'h00;
        nxt_row = 16'h0000;
        nxt_base = `FAS_BASE_RST;
        nxt_parity = 1'b0;
      end
      `FAS_INSTR_RESET_LOAD: begin
        nxt_stage = 5'h00;
        nxt_row = 16'h0000;
        nxt_base = addr_in;
        nxt_parity = 1'b0;
      end
      `FAS_INSTR_COUNT: begin
        // Stops at the final butterfly rather than wrapping
        if (cur_tdone) begin
          nxt_row = row_ff;
        end else if (cur_sdone) begin
          nxt_row = 16'h0000;
          nxt_stage = stage_ff + 5'h01;
          nxt_parity = !parity_ff;
        end else begin
          nxt_row = row_ff + 16'h0001;
        end
      end
      default: begin
        nxt_row = row_ff;
      end
    endcase
  end

  // Address generators, evaluated on the state that follows the edge
  always_comb begin
    n_pts_bits = 5'(nxt_len) + 5'h01;
    n_w = fas_width(nxt_len, nxt_cfg[0]);
    n_stages = (n_w == 2'h2) ? (n_pts_bits >> 1) : n_pts_bits;
    n_rows_last = fas_rows_last(n_pts_bits, n_w);
    // Time decimation walks the stages in the opposite order
    s_eff = nxt_cfg[1] ? (n_stages - 5'h01 - nxt_stage) : nxt_stage;
    leg = (n_w == 2'h2) ? address_source_select[1:0] : {1'b0, address_source_select[0]};
    gen_a = 16'((32'(nxt_row) >> fas_digit_pos(n_pts_bits, n_w, s_eff)) << (fas_digit_pos(n_pts_bits, n_w, s_eff) + 5'(n_w)))
          | 16'(32'(leg) << fas_digit_pos(n_pts_bits, n_w, s_eff))
          | (nxt_row & fas_low_mask(fas_digit_pos(n_pts_bits, n_w, s_eff)));
    // Coefficient: zero for leg 0, then leg times the bit-reversed group angle
    coef_a = 16'(32'(leg) * 32'(fas_bitrev16(nxt_row >> fas_digit_pos(n_pts_bits, n_w, s_eff)) >> n_w));
    // Reversal over the used bits only; upper bits come from the block base
    din_a = nxt_cfg[2] ? (fas_bitrev16(gen_a) >> (5'h10 - n_pts_bits)) : gen_a;
    dout_a = nxt_cfg[2] ? gen_a : (fas_bitrev16(gen_a) >> (5'h10 - n_pts_bits));
    din_a = (nxt_base & ~fas_low_mask(n_pts_bits)) | (din_a & fas_low_mask(n_pts_bits));
    dout_a = (nxt_base & ~fas_low_mask(n_pts_bits)) | (dout_a & fas_low_mask(n_pts_bits));
    case (address_source_select[3:2])
      `FAS_SRC_IN_DATA: nxt_addr = din_a;
      `FAS_SRC_OUT_DATA: nxt_addr = dout_a;
      `FAS_SRC_COEF: nxt_addr = coef_a;
      default: nxt_addr = nxt_base;
    endcase
    nxt_sdone = (nxt_row == n_rows_last);
    nxt_tdone = nxt_sdone && (nxt_stage == n_stages - 5'h01);
    // Shared pin: nonzero coefficient during real-input data addressing
    if (rvi_mode && !address_source_select[3]) begin
      nxt_flag = (coef_a != 16'h0000);
    end else begin
      nxt_flag = nxt_parity;
    end
  end

  // State and output registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage_ff <= 5'h00;
      row_ff <= 16'h0000;
      base_ff <= `FAS_BASE_RST;
      parity_ff <= 1'b0;
      len_ff <= `FAS_LEN_RST;
      cfg_ff <= `FAS_CFG_RST;
      addr_ff <= 16'h0000;
      oe_ff <= 1'b0;
      sdone_ff <= `FAS_DONE_RST; // Matches row 0 of the two-point default
      tdone_ff <= `FAS_DONE_RST; // Single stage, so also the final butterfly
      flag_ff <= 1'b0;
    end else begin
      stage_ff <= nxt_stage;
      row_ff <= nxt_row;
      base_ff <= nxt_base;
      parity_ff <= nxt_parity;
      len_ff <= nxt_len;
      cfg_ff <= nxt_cfg;
      addr_ff <= nxt_addr;
      oe_ff <= output_enable;
      sdone_ff <= nxt_sdone;
      tdone_ff <= nxt_tdone;
      flag_ff <= nxt_flag;
    end
  end

  assign addr_out = addr_ff;
  assign addr_oe = oe_ff;
  assign stage_done_flag = sdone_ff;
  assign transform_done_flag = tdone_ff;
  assign parity_nonzero_flag = flag_ff;

  // Register access: mode control in, counter state out
  fas_axil_slave #(.ADDR_W(8)) u_regs (
    .clk_sys(clk_sys),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rvi_mode(rvi_mode),
    .stat_stage(stage_ff),
    .stat_row(row_ff),
    .stat_sdone(sdone_ff),
    .stat_tdone(tdone_ff),
    .stat_flag(flag_ff),
    .stat_len(len_ff),
    .stat_cfg(cfg_ff),
    .stat_addr(addr_ff)
  );

  // Checks on the counter, flags and address port
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_len_latch;
    length_latch_select && length_latch_strobe |=> len_ff == $past(length_code_inputs);
  endproperty
  a_len_latch: assert property (p_len_latch) else $error("length code not latched");

  property p_reset;
    instr == `FAS_INSTR_RESET |=> stage_ff == 5'h00 && row_ff == 16'h0000 && base_ff == 16'h0000 && !parity_ff;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not clear counter");

  property p_load;
    instr == `FAS_INSTR_RESET_LOAD |=> base_ff == $past(addr_in) && row_ff == 16'h0000;
  endproperty
  a_load: assert property (p_load) else $error("block base not loaded");

  property p_hold;
    instr == `FAS_INSTR_HOLD |=> $stable(stage_ff) && $stable(row_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("hold moved the counter");

  property p_hold_flags;
    instr == `FAS_INSTR_HOLD && $past(instr) == `FAS_INSTR_HOLD && !length_latch_strobe && !config_latch_strobe
      |=> $stable(stage_done_flag) && $stable(transform_done_flag);
  endproperty
  a_hold_flags: assert property (p_hold_flags) else $error("flags changed under hold");

  property p_count;
    instr == `FAS_INSTR_COUNT && !cur_sdone |=> row_ff == $past(row_ff) + 16'h0001 && $stable(stage_ff);
  endproperty
  a_count: assert property (p_count) else $error("count did not advance row");

  property p_stage_step;
    instr == `FAS_INSTR_COUNT && cur_sdone && !cur_tdone
      |=> row_ff == 16'h0000 && stage_ff == $past(stage_ff) + 5'h01 && parity_ff != $past(parity_ff);
  endproperty
  a_stage_step: assert property (p_stage_step) else $error("stage step or parity wrong");

  property p_sdone;
    stage_done_flag == (row_ff == cur_rows_last) || $changed(len_ff) || $changed(cfg_ff);
  endproperty
  a_sdone: assert property (p_sdone) else $error("stage done flag mismatch");

  property p_tdone;
    transform_done_flag |-> stage_done_flag;
  endproperty
  a_tdone: assert property (p_tdone) else $error("transform done without stage done");

  property p_oe;
    !output_enable |=> !addr_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("address lines driven while disabled");

  property p_parity_pin;
    !rvi_mode ##1 !$past(rvi_mode) |-> parity_nonzero_flag == parity_ff;
  endproperty
  a_parity_pin: assert property (p_parity_pin) else $error("shared flag not showing parity");

  c_done: cover property (transform_done_flag);
  c_load: cover property (instr == `FAS_INSTR_RESET_LOAD ##1 instr == `FAS_INSTR_COUNT);
  c_stage: cover property (stage_done_flag ##1 instr == `FAS_INSTR_COUNT ##1 stage_ff == 5'h02);

endmodule

// ---- hw/fas_defines.svh ----
`ifndef FAS_DEFINES_SVH
`define FAS_DEFINES_SVH

// Counter instruction codes on {instr_select_high, instr_select_low}
`define FAS_INSTR_RESET 2'h0
`define FAS_INSTR_RESET_LOAD 2'h1
`define FAS_INSTR_COUNT 2'h2
`define FAS_INSTR_HOLD 2'h3

// Address source codes on address_source_select[3:2]
`define FAS_SRC_IN_DATA 2'h0
`define FAS_SRC_OUT_DATA 2'h1
`define FAS_SRC_COEF 2'h2
`define FAS_SRC_BASE 2'h3

// Widths
`define FAS_ADDR_W 16
`define FAS_LEN_W 4

// Register byte offsets
`define FAS_REG_CTRL 8'h00
`define FAS_REG_STATUS 8'h04
`define FAS_REG_POS 8'h08
`define FAS_REG_CONFIG 8'h0C
`define FAS_REG_ADDR 8'h10

// Field positions
`define FAS_CTRL_RVI_BIT 0
`define FAS_STAT_SDONE_BIT 5
`define FAS_STAT_TDONE_BIT 6
`define FAS_STAT_FLAG_BIT 7

// Reset values
`define FAS_CTRL_RST 1'h0
`define FAS_BASE_RST 16'h0000
`define FAS_LEN_RST 4'h0
`define FAS_CFG_RST 3'h0
// The default two-point length puts the counter on its only butterfly, which is also its last
`define FAS_DONE_RST 1'h1

// AXI responses
`define FAS_RESP_OKAY 2'h0
`define FAS_RESP_DECERR 2'h3

`endif

// ---- hw/fas_pkg.sv ----
package fas_pkg;
  // Two-bit counter instruction as seen on the pins
  typedef logic [1:0] fas_instr_type;
  // Bus channel state of the register slave
  typedef enum logic [0:0] {BUS_IDLE, BUS_RESP} fas_bus_state_type;
endpackage

// ---- hw/fas_axil_slave.sv ----
`timescale 1ns/1ps
`include "fas_defines.svh"

module fas_axil_slave #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic rvi_mode, // Real-valued-input mode
  input wire logic [4:0] stat_stage, // Current stage
  input wire logic [15:0] stat_row, // Current row
  input wire logic stat_sdone, // Stage done
  input wire logic stat_tdone, // Transform done
  input wire logic stat_flag, // Shared parity/nonzero flag
  input wire logic [3:0] stat_len, // Latched length code
  input wire logic [2:0] stat_cfg, // Latched configuration
  input wire logic [15:0] stat_addr // Address output
);

  // The register map reaches offset 0x10, so five address bits at least
  if (ADDR_W < 5) begin : g_addr_w_check
    $error("ADDR_W too small for the register map");
  end

  logic aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
  logic [ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
  logic [31:0] w_data_ff, nxt_w_data;
  logic w_strb0_ff, nxt_w_strb0;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic ctrl_rvi_ff, nxt_ctrl_rvi;
  fas_pkg::fas_bus_state_type rd_state_ff, nxt_rd_state;
  logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic commit;

  // Address map check, shared by both channels
  function automatic logic fas_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    return (b == `FAS_REG_CTRL) || (b == `FAS_REG_STATUS) || (b == `FAS_REG_POS) ||
           (b == `FAS_REG_CONFIG) || (b == `FAS_REG_ADDR);
  endfunction

  // Write side: address and data are taken in either order, committed together
  always_comb begin
    commit = aw_have_ff && w_have_ff && !bvalid_ff;
    nxt_aw_have = aw_have_ff || (s_axi_awvalid && awready_ff);
    nxt_aw_addr = (s_axi_awvalid && awready_ff) ? s_axi_awaddr : aw_addr_ff;
    nxt_w_have = w_have_ff || (s_axi_wvalid && wready_ff);
    nxt_w_data = (s_axi_wvalid && wready_ff) ? s_axi_wdata : w_data_ff;
    nxt_w_strb0 = (s_axi_wvalid && wready_ff) ? s_axi_wstrb[0] : w_strb0_ff;
    nxt_bvalid = bvalid_ff && !s_axi_bready;
    nxt_bresp = bresp_ff;
    nxt_ctrl_rvi = ctrl_rvi_ff;
    if (commit) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = fas_mapped(aw_addr_ff) ? `FAS_RESP_OKAY : `FAS_RESP_DECERR;
      // Read-only registers accept writes silently
      if (8'(aw_addr_ff) == `FAS_REG_CTRL && w_strb0_ff) begin
        nxt_ctrl_rvi = w_data_ff[`FAS_CTRL_RVI_BIT];
      end
    end
    nxt_awready = !nxt_aw_have;
    nxt_wready = !nxt_w_have;
  end

  // Read side: one read at a time, data registered with the answer
  always_comb begin
    nxt_rd_state = rd_state_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    case (rd_state_ff)
      fas_pkg::BUS_IDLE: begin
        if (s_axi_arvalid && arready_ff) begin
          nxt_rd_state = fas_pkg::BUS_RESP;
          nxt_rvalid = 1'b1;
          nxt_rresp = fas_mapped(s_axi_araddr) ? `FAS_RESP_OKAY : `FAS_RESP_DECERR;
          case (8'(s_axi_araddr))
            `FAS_REG_CTRL: nxt_rdata = {31'h00000000, ctrl_rvi_ff};
            `FAS_REG_STATUS: nxt_rdata = {24'h000000, stat_flag, stat_tdone, stat_sdone, stat_stage};
            `FAS_REG_POS: nxt_rdata = {16'h0000, stat_row};
            `FAS_REG_CONFIG: nxt_rdata = {25'h0000000, stat_cfg, stat_len};
            `FAS_REG_ADDR: nxt_rdata = {16'h0000, stat_addr};
            default: nxt_rdata = 32'h00000000;
          endcase
        end
      end
      fas_pkg::BUS_RESP: begin
        if (s_axi_rready) begin
          nxt_rd_state = fas_pkg::BUS_IDLE;
          nxt_rvalid = 1'b0;
        end
      end
      default: nxt_rd_state = fas_pkg::BUS_IDLE;
    endcase
    nxt_arready = (nxt_rd_state == fas_pkg::BUS_IDLE);
  end

  // Channel registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_have_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_have_ff <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_strb0_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `FAS_RESP_OKAY;
      ctrl_rvi_ff <= `FAS_CTRL_RST;
      rd_state_ff <= fas_pkg::BUS_IDLE;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `FAS_RESP_OKAY;
    end else begin
      aw_have_ff <= nxt_aw_have;
      aw_addr_ff <= nxt_aw_addr;
      w_have_ff <= nxt_w_have;
      w_data_ff <= nxt_w_data;
      w_strb0_ff <= nxt_w_strb0;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      ctrl_rvi_ff <= nxt_ctrl_rvi;
      rd_state_ff <= nxt_rd_state;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign rvi_mode = ctrl_rvi_ff;

endmodule

// ---- dv/fas_mem_model.sv ----
`timescale 1ns/1ps
module fas_mem_model (
  input wire logic clk_sys, // Clock
  input wire logic [15:0] addr_out, // Sequencer value
  input wire logic addr_oe, // Sequencer enable
  input wire logic base_en, // Base drive enable
  input wire logic [15:0] base, // Block base
  output logic [15:0] bus // Resolved lines
);
  logic [15:0] last_ff;
  // Floating lines show the inverse of the last value, never a stale copy
  assign bus = addr_oe ? addr_out : (base_en ? base : ~last_ff);
  always_ff @(posedge clk_sys) begin
    last_ff <= bus;
  end
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`include "fas_defines.svh"
module tb;
  logic clk_sys = 1'h0, rst = 1'h1, lat = 1'h0, oe = 1'h1, ben = 1'h0;
  logic [1:0] ins = 2'h3;
  logic [3:0] len = 4'h3, src = 4'h1;
  logic [2:0] cfg = 3'h0;
  logic [15:0] bus, ao;
  logic aoe, sd, td, pf, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic awr, wr, bv, arr, rv;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdt;
  logic [1:0] br, rr;
  int error_cnt = 0, samples_checked = 0;
  always #5 clk_sys = ~clk_sys;
  fas_sequencer u_dut (.clk_sys(clk_sys), .rst(rst), .instr_select_low(ins[0]), .instr_select_high(ins[1]),
    .length_code_inputs(len), .length_latch_select(lat), .length_latch_strobe(lat),
    .digit_reversal_side_select(cfg[2]), .decimation_type_select(cfg[1]), .radix_select(cfg[0]),
    .config_latch_select(lat), .config_latch_strobe(lat), .address_source_select(src), .output_enable(oe),
    .addr_in(bus), .addr_out(ao), .addr_oe(aoe), .stage_done_flag(sd), .transform_done_flag(td),
    .parity_nonzero_flag(pf), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry));
  fas_mem_model u_mem (.clk_sys(clk_sys), .addr_out(ao), .addr_oe(aoe), .base_en(ben), .base(16'hABC0), .bus(bus));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task give_verdict;
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One instruction, then Hold, so exactly one edge executes it
  task cyc(input logic [1:0] i);
    @(posedge clk_sys);
    ins <= i;
    @(posedge clk_sys);
    ins <= `FAS_INSTR_HOLD;
    @(negedge clk_sys);
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awa <= a;
    wd <= d;
    {awv, wv, bry} <= 3'h7;
    do begin
      @(posedge clk_sys);
      if (awr) awv <= 1'h0;
      if (wr) wv <= 1'h0;
    end while (bv !== 1'h1);
    bry <= 1'h0;
    chk("bresp", `FAS_RESP_OKAY, br);
  endtask
  task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_sys);
    ara <= a;
    {arv, rry} <= 2'h3;
    do begin
      @(posedge clk_sys);
      if (arr) arv <= 1'h0;
    end while (rv !== 1'h1);
    rry <= 1'h0;
    chk("rdata", e, rdt);
    chk("rresp", er, rr);
  endtask
  initial begin
    int k, sp;
    repeat (12) @(posedge clk_sys);
    rst <= 1'h0;
    lat <= 1'h1;
    @(posedge clk_sys);
    lat <= 1'h0;
    axr(`FAS_REG_CTRL, 32'h0, `FAS_RESP_OKAY);
    axr(`FAS_REG_CONFIG, 32'h3, `FAS_RESP_OKAY);
    axr(8'h40, 32'h0, `FAS_RESP_DECERR);
    cyc(`FAS_INSTR_RESET);
    for (int r = 0; r < 32; r++) begin
      if (r > 0) cyc(`FAS_INSTR_COUNT);
      k = r % 8;
      sp = 8 >> (r / 8);
      chk("addr", k / sp * 2 * sp + k % sp + sp, ao);
      chk("stage_done", k == 7, sd);
      chk("transform_done", r == 31, td);
      chk("parity", r / 8 % 2, pf);
    end
    // A Count past the last butterfly must leave the counter parked
    cyc(`FAS_INSTR_COUNT);
    chk("transform_done", 1'h1, td);
    chk("addr", 16'h000F, ao);
    // Float our side and let the partner drive the block base
    @(posedge clk_sys);
    {oe, ben} <= 2'h1;
    cyc(`FAS_INSTR_RESET_LOAD);
    chk("addr_oe", 1'h0, aoe);
    chk("addr", 16'hABC8, ao);
    @(posedge clk_sys);
    src <= 4'hD;
    cyc(`FAS_INSTR_HOLD);
    chk("base_addr", 16'hABC0, ao);
    @(posedge clk_sys);
    {oe, ben, src} <= 6'h21;
    cyc(`FAS_INSTR_RESET);
    chk("addr", 16'h0008, ao);
    axw(`FAS_REG_CTRL, 32'h1);
    axr(`FAS_REG_CTRL, 32'h1, `FAS_RESP_OKAY);
    repeat (8) cyc(`FAS_INSTR_COUNT);
    chk("nonzero", 1'h0, pf);
    repeat (4) cyc(`FAS_INSTR_COUNT);
    chk("nonzero", 1'h1, pf);
    // Output side of a normal-input in-place transform comes out bit-reversed
    @(posedge clk_sys);
    src <= 4'h5;
    cyc(`FAS_INSTR_HOLD);
    chk("out_addr", 16'h0003, ao);
    @(posedge clk_sys);
    src <= 4'h9;
    cyc(`FAS_INSTR_HOLD);
    chk("coef", 16'h4000, ao);
    // Radix 4 with time decimation: two stages of four butterflies each
    @(posedge clk_sys);
    {cfg, lat, src} <= 8'h71;
    @(posedge clk_sys);
    lat <= 1'h0;
    axr(`FAS_REG_CONFIG, 32'h33, `FAS_RESP_OKAY);
    cyc(`FAS_INSTR_RESET);
    chk("r4_addr", 16'h0001, ao);
    repeat (3) cyc(`FAS_INSTR_COUNT);
    chk("r4_addr", 16'h000D, ao);
    chk("stage_done", 1'h1, sd);
    cyc(`FAS_INSTR_COUNT);
    chk("r4_addr", 16'h0004, ao);
    repeat (3) cyc(`FAS_INSTR_COUNT);
    chk("transform_done", 1'h1, td);
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    error_cnt++;
    give_verdict;
  end
endmodule
